// [pkg/lpt_pkg.sv]
// Purpose : Shared timing constants, types and helpers for the low-power
//           memory power-down sequencer and its timers.
// Assumes : Controller clock of 25 MHz; memory clock is that clock / 2.
// Notes   : Delays are kept in picoseconds plus a memory-clock count, except the
//           set-point and repair times, kept in ns, us or ms; cyc_f turns a pair into controller cycles.
package lpt_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clocking
   localparam int CLK_PERIOD_PS = 40000;          // 25 MHz controller clock
   localparam int CK_DIV        = 2;              // Memory clock divider
   localparam int CK_PERIOD_PS  = CLK_PERIOD_PS * CK_DIV;
   localparam int SYNC_STAGES   = 2;              // Pin synchroniser depth
   localparam int TIMER_W       = 25;

   typedef logic [TIMER_W-1:0] lpt_count_t;

   // Mixed limit: both the analog time and the clock count must pass
   function automatic int cyc_f(input int ps, input int nck);
      int a;
      int b;
      a = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      b = nck * CK_DIV;
      if (b > a) a = b;
      if (a < 1) a = 1;
      return a;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Power-down and command spacing limits
   localparam int CKE_MIN_PS   = 7500;
   localparam int CKE_MIN_NCK  = 4;
   localparam int CMD_CKE_PS   = 1750;
   localparam int CMD_CKE_NCK  = 3;
   localparam int CK_HOLD_PS   = 5000;
   localparam int CK_HOLD_NCK  = 5;
   localparam int CK_SETUP_PS  = 1750;
   localparam int CK_SETUP_NCK = 3;
   localparam int XP_PS        = 7500;
   localparam int XP_NCK       = 5;
   localparam int CS_WAKE_PS   = 7500;
   localparam int CS_WAKE_NCK  = 5;
   localparam int MRW_HOLD_PS  = 14000;
   localparam int MRW_HOLD_NCK = 10;
   localparam int ZQ_HOLD_PS   = 1750;
   localparam int ZQ_HOLD_NCK  = 3;
   localparam int SDO_PS       = 20000;
   localparam int SDO_NCK      = 12;
   localparam int MPCWR_NCK    = 3;
   localparam int OSCO_PS      = 40000;
   localparam int OSCO_NCK     = 8;
   localparam int FC_SHORT_NS  = 200;
   localparam int FC_MIDDLE_NS = 200;
   localparam int FC_LONG_NS   = 250;
   localparam int FSPX_PS      = 7500;
   localparam int FSPX_NCK     = 4;
   localparam int ODTUP_PS     = 20000;
   localparam int ODTUP_NCK    = (ODTUP_PS + CK_PERIOD_PS - 1) / CK_PERIOD_PS;
   localparam int DES_NCK      = 2;               // Quiet slots after MPC
   localparam int PGM_MS       = 1000;
   localparam int PGM_EXIT_NS  = 15;
   localparam int PGM_PST_US   = 50;
   localparam int DERATE_RCD_PS   = 1875;
   localparam int DERATE_RC_PS    = 3750;
   localparam int DQSCK_DERATE_PS = 3600;
   localparam int HOT_LOW_C       = 85;
   localparam int HOT_HIGH_C      = 95;

   // Derived controller cycle counts
   localparam lpt_count_t CKE_MIN_CYC  =
      lpt_count_t'(cyc_f(CKE_MIN_PS, CKE_MIN_NCK));
   localparam lpt_count_t CMD_CKE_CYC  =
      lpt_count_t'(cyc_f(CMD_CKE_PS, CMD_CKE_NCK));
   localparam lpt_count_t CK_HOLD_CYC  =
      lpt_count_t'(cyc_f(CK_HOLD_PS, CK_HOLD_NCK));
   localparam lpt_count_t CK_SETUP_CYC =
      lpt_count_t'(cyc_f(CK_SETUP_PS, CK_SETUP_NCK));
   localparam lpt_count_t XP_CYC       = lpt_count_t'(cyc_f(XP_PS, XP_NCK));
   localparam lpt_count_t CS_WAKE_CYC  =
      lpt_count_t'(cyc_f(CS_WAKE_PS, CS_WAKE_NCK));
   localparam lpt_count_t MRW_HOLD_CYC =
      lpt_count_t'(cyc_f(MRW_HOLD_PS, MRW_HOLD_NCK));
   localparam lpt_count_t ZQ_HOLD_CYC  =
      lpt_count_t'(cyc_f(ZQ_HOLD_PS, ZQ_HOLD_NCK));
   localparam lpt_count_t SDO_CYC      = lpt_count_t'(cyc_f(SDO_PS, SDO_NCK));
   localparam lpt_count_t OSCO_CYC     =
      lpt_count_t'(cyc_f(OSCO_PS, OSCO_NCK));
   localparam lpt_count_t FC_SHORT_CYC =
      lpt_count_t'(cyc_f(FC_SHORT_NS * 1000, 0));
   localparam lpt_count_t FC_MIDDLE_CYC =
      lpt_count_t'(cyc_f(FC_MIDDLE_NS * 1000, 0));
   localparam lpt_count_t FC_LONG_CYC  =
      lpt_count_t'(cyc_f(FC_LONG_NS * 1000, 0));
   localparam lpt_count_t FSPX_CYC     =
      lpt_count_t'(cyc_f(FSPX_PS, FSPX_NCK));
   localparam lpt_count_t ODTUP_CYC    =
      lpt_count_t'(cyc_f(ODTUP_PS, ODTUP_NCK));
   localparam lpt_count_t DES_CYC      = lpt_count_t'(cyc_f(0, DES_NCK));
   localparam lpt_count_t MPCWR_CYC    = lpt_count_t'(cyc_f(0, MPCWR_NCK));
   localparam lpt_count_t PGM_EXIT_CYC =
      lpt_count_t'(cyc_f(PGM_EXIT_NS * 1000, 0));
   // Exact divisions at 40 ns, so no rounding is lost here
   localparam int PPR_PGM_CYC = PGM_MS * (1000000000 / CLK_PERIOD_PS);
   localparam lpt_count_t PGM_PST_CYC =
      lpt_count_t'(PGM_PST_US * (1000000 / CLK_PERIOD_PS));

   ////////////////////////////////////////////////////////////////////////////
   // Timer slots
   localparam int TM_CKE    = 0;
   localparam int TM_CMDCKE = 1;
   localparam int TM_HOLD   = 2;
   localparam int TM_SETUP  = 3;
   localparam int TM_GUARD  = 4;
   localparam int TM_WFIFO  = 5;
   localparam int TM_TRAIN  = 6;
   localparam int TM_N      = 7;

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [3:0] {
      OP_CMD, OP_MRW, OP_ZQ_START, OP_OSC_STOP, OP_WFIFO, OP_ODT_UPDATE,
      OP_FSP_SWITCH, OP_PPR, OP_TRAIN, OP_PD_ENTER, OP_PD_EXIT
   } lpt_op_e;

   typedef enum logic [1:0] {FSP_SHORT, FSP_MIDDLE, FSP_LONG} lpt_fsp_e;

   typedef enum logic [2:0] {
      ST_IDLE, ST_CMD2, ST_PD_HOLD, ST_SLEEP, ST_CLKUP
   } lpt_state_e;

   typedef struct packed {
      lpt_op_e    op;
      logic [5:0] ca_r1;
      logic [5:0] ca_r2;
      lpt_fsp_e   fsp;
   } lpt_req_s;

   typedef struct packed {
      logic       cke;
      logic       cs;
      logic [5:0] ca;
   } lpt_pins_s;

endpackage

// [src/lpt_timer.sv]
// Purpose : Loadable down-counter guarding one timing limit.
// Assumes : Load value already expressed in controller cycles.
// Notes   : DONE is high while the count is zero; a load of N makes DONE
//           return N edges later.
module lpt_timer (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Load side
   input  wire logic             load,
   input  lpt_pkg::lpt_count_t   value,
   // Status
   output logic                  done
);

   lpt_pkg::lpt_count_t count;

   ////////////////////////////////////////////////////////////////////////////
   // Count down to zero and rest there
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count <= '0;
      end else if (load) begin
         count <= value;
      end else if (count != '0) begin
         count <= count - lpt_pkg::lpt_count_t'(1);
      end
   end

   assign done = (count == '0);

endmodule

// [src/lpt_pd_ctrl.sv]
// Purpose : Host-side sequencer that drives clock, clock enable, select and
//           command/address of a low-power memory through power-down entry
//           and exit and guards mode-transition command spacing.
// Assumes : Memory clock made here by dividing CLK by two; HOT and the
//           request port come from logic on CLK; DQS comes from the pin.
// Notes   : One request at a time; READY low while one is in flight.

//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Hold clock enable high or low at least max(7.5 ns, 4 clocks).
// - Wait max(1.75 ns, 3 clocks) after a command before clock enable low.
// - Keep clock and select valid max(5 ns, 5 clocks) after enable low.
// - Run a valid clock max(1.75 ns, 3 clocks) before raising enable.
// - After wake wait max(7.5 ns, 5 clocks) before the next command.
// - Keep select valid max(7.5 ns, 5 clocks) after enable rises.
// - After a mode write, hold clock and select max(14 ns, 10 clocks).
// - After calibration start, hold clock and select max(1.75 ns, 3 clocks).
// - Every mixed limit waits for both its time and its clock count.
// - FIFO write waits wake delay plus row-to-column delay plus 3 clocks.
// - Oscillator count readout waits max(40 ns, 8 clocks) after stop.
// - Set-point switch takes 200 ns short or middle, 250 ns long.
// - After a set-point change, valid clock max(7.5 ns, 4) before command.
// - Data reference voltage gets the same settling as command reference.
// - Termination update waits 20 ns rounded up to whole clocks.
// - Repair allows 1000 ms program, 15 ns exit, 50 us new address.
// - Derating adds 1.875 ns to row delays, 3.75 ns to row cycle; only the row-to-column delay is derated here.
// - Derated values apply while hot, between 85 and 95 degrees.
module lpt_pd_ctrl #(
   parameter int PPR_PROGRAM_CYC = lpt_pkg::PPR_PGM_CYC,
   parameter int TRCD_PS         = 18000
) (
   // Clock and reset
   input  wire logic               CLK,
   input  wire logic               RST_N,
   // Request port
   input  wire logic               REQ,
   input  wire lpt_pkg::lpt_req_s  REQ_DATA,
   input  wire logic               HOT,
   output logic                    READY,
   output logic                    ACK,
   output logic                    ERR,
   // Status
   output logic                    POWERED_DOWN,
   output logic                    TRAIN_FAIL,
   // Memory pins
   output logic                    CK,
   output lpt_pkg::lpt_pins_s      PINS,
   input  wire logic               DQS
);

   // Row-to-column delay in cycles, plain and derated
   localparam lpt_pkg::lpt_count_t RCD_CYC =
      lpt_pkg::lpt_count_t'(lpt_pkg::cyc_f(TRCD_PS, 0));
   localparam lpt_pkg::lpt_count_t RCD_HOT_CYC =
      lpt_pkg::lpt_count_t'(lpt_pkg::cyc_f(TRCD_PS +
                                           lpt_pkg::DERATE_RCD_PS, 0));

   lpt_pkg::lpt_state_e  state;
   lpt_pkg::lpt_req_s    preq;
   logic                 pend;
   logic                 ck_run;
   logic                 last_mrw;
   logic                 last_zq;
   logic                 train_active;
   logic                 dqs_meta;
   logic                 dqs_sync;
   logic                 tick;
   logic                 go_cmd1;
   logic                 go_cmd2;
   logic                 go_pd_low;
   logic                 go_stop;
   logic                 go_clk_up;
   logic                 go_wake;
   logic                 go_bad;
   logic                 finish;
   logic [lpt_pkg::TM_N-1:0] tm_load;
   logic [lpt_pkg::TM_N-1:0] tm_done;
   lpt_pkg::lpt_count_t  tm_val [lpt_pkg::TM_N];
   lpt_pkg::lpt_count_t  hold_cyc;

   ////////////////////////////////////////////////////////////////////////////
   // Decoding helpers

   // Ops that put a two-slot command on the bus
   function automatic logic is_cmd_f(input lpt_pkg::lpt_op_e op);
      return (op != lpt_pkg::OP_PD_ENTER) && (op != lpt_pkg::OP_PD_EXIT);
   endfunction

   // Quiet time that must follow a command before the next one
   function automatic lpt_pkg::lpt_count_t guard_f(
      input lpt_pkg::lpt_op_e  op,
      input lpt_pkg::lpt_fsp_e fsp
   );
      lpt_pkg::lpt_count_t g;
      g = lpt_pkg::lpt_count_t'(1);
      case (op)
         lpt_pkg::OP_ZQ_START: g = lpt_pkg::DES_CYC;
         lpt_pkg::OP_OSC_STOP: g = lpt_pkg::OSCO_CYC;
         lpt_pkg::OP_ODT_UPDATE: g = lpt_pkg::ODTUP_CYC;
         lpt_pkg::OP_FSP_SWITCH: begin
            // Long wait also covers data reference settling
            case (fsp)
               lpt_pkg::FSP_LONG: g = lpt_pkg::FC_LONG_CYC;
               lpt_pkg::FSP_MIDDLE: g = lpt_pkg::FC_MIDDLE_CYC;
               default: g = lpt_pkg::FC_SHORT_CYC;
            endcase
            g = g + lpt_pkg::FSPX_CYC;
         end
         lpt_pkg::OP_PPR: begin
            // Program, exit and address setting run back to back
            g = lpt_pkg::lpt_count_t'(PPR_PROGRAM_CYC) +
                lpt_pkg::PGM_EXIT_CYC + lpt_pkg::PGM_PST_CYC;
         end
         default: g = lpt_pkg::lpt_count_t'(1);
      endcase
      return g;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Strobe pin synchroniser
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         dqs_meta <= 1'b0;
         dqs_sync <= 1'b0;
      end else begin
         dqs_meta <= DQS;
         dqs_sync <= dqs_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Memory clock divider; stops low only, so no runt pulse reaches the pin
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         CK <= 1'b0;
      end else if (ck_run) begin
         CK <= ~CK;
      end else begin
         CK <= 1'b0;
      end
   end

   // Bus changes happen as CK falls, so each slot is stable at its rise
   assign tick = ck_run & CK;

   ////////////////////////////////////////////////////////////////////////////
   // Per-limit timers
   generate
      for (genvar i = 0; i < lpt_pkg::TM_N; i++) begin : g_tm
         lpt_timer u_tm (
            .clk   (CLK),
            .rst_n (RST_N),
            .load  (tm_load[i]),
            .value (tm_val[i]),
            .done  (tm_done[i])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Step conditions of the sequencer
   always_comb begin
      go_cmd1   = pend && state == lpt_pkg::ST_IDLE && tick &&
                  tm_done[lpt_pkg::TM_GUARD] && is_cmd_f(preq.op) &&
                  (preq.op != lpt_pkg::OP_WFIFO ||
                   tm_done[lpt_pkg::TM_WFIFO]);
      go_pd_low = pend && state == lpt_pkg::ST_IDLE && tick &&
                  preq.op == lpt_pkg::OP_PD_ENTER &&
                  tm_done[lpt_pkg::TM_GUARD] &&
                  tm_done[lpt_pkg::TM_CKE] &&
                  tm_done[lpt_pkg::TM_CMDCKE];
      go_cmd2   = state == lpt_pkg::ST_CMD2 && tick;
      go_stop   = state == lpt_pkg::ST_PD_HOLD && tick &&
                  tm_done[lpt_pkg::TM_HOLD];
      go_clk_up = pend && state == lpt_pkg::ST_SLEEP &&
                  preq.op == lpt_pkg::OP_PD_EXIT &&
                  tm_done[lpt_pkg::TM_CKE];
      go_wake   = state == lpt_pkg::ST_CLKUP && tick &&
                  tm_done[lpt_pkg::TM_SETUP];
      go_bad    = pend &&
                  ((state == lpt_pkg::ST_IDLE &&
                    preq.op == lpt_pkg::OP_PD_EXIT) ||
                   (state == lpt_pkg::ST_SLEEP &&
                    preq.op != lpt_pkg::OP_PD_EXIT));
      finish    = go_cmd2 | go_stop | go_wake | go_bad;
   end

   // Hold after enable low depends on the last command
   always_comb begin
      hold_cyc = lpt_pkg::CK_HOLD_CYC;
      if (last_mrw && lpt_pkg::MRW_HOLD_CYC > hold_cyc) begin
         hold_cyc = lpt_pkg::MRW_HOLD_CYC;
      end
      if (last_zq && lpt_pkg::ZQ_HOLD_CYC > hold_cyc) begin
         hold_cyc = lpt_pkg::ZQ_HOLD_CYC;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timer loads; each value already waits for the later of ns and clocks
   always_comb begin
      tm_load = '0;
      for (int i = 0; i < lpt_pkg::TM_N; i++) begin
         tm_val[i] = '0;
      end
      tm_load[lpt_pkg::TM_CKE]   = go_pd_low | go_wake;
      tm_val[lpt_pkg::TM_CKE]    = lpt_pkg::CKE_MIN_CYC;
      tm_load[lpt_pkg::TM_CMDCKE] = go_cmd2;
      tm_val[lpt_pkg::TM_CMDCKE]  = lpt_pkg::CMD_CKE_CYC;
      tm_load[lpt_pkg::TM_HOLD]  = go_pd_low;
      tm_val[lpt_pkg::TM_HOLD]   = hold_cyc;
      tm_load[lpt_pkg::TM_SETUP] = go_clk_up;
      tm_val[lpt_pkg::TM_SETUP]  = lpt_pkg::CK_SETUP_CYC;
      tm_load[lpt_pkg::TM_GUARD] = go_cmd2 | go_wake;
      if (go_wake) begin
         // Select stays deselected until both wake limits pass
         tm_val[lpt_pkg::TM_GUARD] =
            (lpt_pkg::XP_CYC > lpt_pkg::CS_WAKE_CYC) ?
            lpt_pkg::XP_CYC : lpt_pkg::CS_WAKE_CYC;
      end else begin
         tm_val[lpt_pkg::TM_GUARD] = guard_f(preq.op, preq.fsp);
      end
      // Derated row delay is used while the part runs hot
      tm_load[lpt_pkg::TM_WFIFO] = go_wake;
      tm_val[lpt_pkg::TM_WFIFO]  = lpt_pkg::XP_CYC +
                                   (HOT ? RCD_HOT_CYC : RCD_CYC) +
                                   lpt_pkg::MPCWR_CYC;
      // Allow for the synchroniser delay on the strobe
      tm_load[lpt_pkg::TM_TRAIN] = go_cmd2 &&
                                   preq.op == lpt_pkg::OP_TRAIN;
      tm_val[lpt_pkg::TM_TRAIN]  = lpt_pkg::SDO_CYC +
                                   lpt_pkg::lpt_count_t'(lpt_pkg::SYNC_STAGES);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Request holding register
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         pend  <= 1'b0;
         READY <= 1'b1;
         preq  <= '0;
      end else if (REQ && READY) begin
         pend  <= 1'b1;
         READY <= 1'b0;
         preq  <= REQ_DATA;
      end else if (finish) begin
         pend  <= 1'b0;
         READY <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Completion pulses
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ACK <= 1'b0;
         ERR <= 1'b0;
      end else begin
         ACK <= finish;
         ERR <= go_bad;   // Exit while awake or command while asleep
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer state
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         state <= lpt_pkg::ST_IDLE;
      end else begin
         case (state)
            lpt_pkg::ST_IDLE: begin
               if (go_cmd1) begin
                  state <= lpt_pkg::ST_CMD2;
               end else if (go_pd_low) begin
                  state <= lpt_pkg::ST_PD_HOLD;
               end
            end
            lpt_pkg::ST_CMD2: begin
               if (go_cmd2) state <= lpt_pkg::ST_IDLE;
            end
            lpt_pkg::ST_PD_HOLD: begin
               if (go_stop) state <= lpt_pkg::ST_SLEEP;
            end
            lpt_pkg::ST_SLEEP: begin
               if (go_clk_up) state <= lpt_pkg::ST_CLKUP;
            end
            lpt_pkg::ST_CLKUP: begin
               if (go_wake) state <= lpt_pkg::ST_IDLE;
            end
            default: state <= lpt_pkg::ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock gating: stop after the hold, restart on an exit request
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ck_run <= 1'b1;
      end else if (go_stop) begin
         ck_run <= 1'b0;
      end else if (go_clk_up) begin
         ck_run <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Memory pins and power-down status
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         PINS         <= '{cke: 1'b1, cs: 1'b0, ca: 6'h00};
         POWERED_DOWN <= 1'b0;
      end else begin
         if (go_cmd1) begin
            PINS.cs <= 1'b1;
            PINS.ca <= preq.ca_r1;
         end else if (go_cmd2) begin
            PINS.cs <= 1'b0;
            PINS.ca <= preq.ca_r2;
         end
         if (go_pd_low) begin
            PINS.cke     <= 1'b0;
            POWERED_DOWN <= 1'b1;
         end else if (go_wake) begin
            PINS.cke     <= 1'b1;
            POWERED_DOWN <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Last command kind, for the hold length at power-down entry
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         last_mrw <= 1'b0;
         last_zq  <= 1'b0;
      end else if (go_cmd2) begin
         last_mrw <= preq.op == lpt_pkg::OP_MRW ||
                     preq.op == lpt_pkg::OP_TRAIN ||
                     preq.op == lpt_pkg::OP_FSP_SWITCH;
         last_zq  <= preq.op == lpt_pkg::OP_ZQ_START;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Training check: the strobe must show up before the deadline
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         train_active <= 1'b0;
         TRAIN_FAIL   <= 1'b0;
      end else if (tm_load[lpt_pkg::TM_TRAIN]) begin
         train_active <= 1'b1;
         TRAIN_FAIL   <= 1'b0;
      end else if (train_active && dqs_sync) begin
         train_active <= 1'b0;
      end else if (train_active && tm_done[lpt_pkg::TM_TRAIN]) begin
         train_active <= 1'b0;
         TRAIN_FAIL   <= 1'b1;
      end
   end

endmodule

// [sim/lpt_pd_ctrl_chk.sv]
// Purpose : Pin timing checks on the power-down sequencer.
// Assumes : CK changes on every CLK edge while the memory clock runs.
// Notes   : Figures are CLK cycles, two for each memory clock.
module lpt_pd_chk (
   // Clock, reset and watched pins
   input wire logic               CLK,
   input wire logic               RST_N,
   input wire logic               CK,
   input wire logic               POWERED_DOWN,
   input wire lpt_pkg::lpt_pins_s PINS
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       ck_q;
   logic [7:0] run;
   // Run of clock toggles; saturates so a long run never wraps to zero
   always_ff @(posedge CLK) begin
      ck_q <= CK;
      run  <= (!RST_N || CK == ck_q) ? 8'h00 : run + {7'h00, ~&run};
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   ////////////////////////////////////////////////////////////////////////////
   property p_low_min; $fell(PINS.cke) |-> !PINS.cke [*8]; endproperty
   a_low_min: assert property (p_low_min)
      else $error("clock enable low pulse too short");
   property p_high_min; $rose(PINS.cke) |-> PINS.cke [*8]; endproperty
   a_high_min: assert property (p_high_min)
      else $error("clock enable high pulse too short");
   property p_cmd_cke; PINS.cs |-> PINS.cke [*6]; endproperty
   a_cmd_cke: assert property (p_cmd_cke)
      else $error("clock enable fell too soon after a command");
   property p_ck_hold; $fell(PINS.cke) |=> $changed(CK) [*8]; endproperty
   a_ck_hold: assert property (p_ck_hold)
      else $error("clock stopped too soon after clock enable fell");
   property p_ck_setup; $rose(PINS.cke) |-> run >= 8'h06; endproperty
   a_ck_setup: assert property (p_ck_setup)
      else $error("clock enable rose without enough running clock");
   property p_wake_cmd;
      $rose(PINS.cke) |-> !PINS.cs [*8] ##1 !PINS.cs [*2];
   endproperty
   a_wake_cmd: assert property (p_wake_cmd)
      else $error("command issued too soon after wake");
   property p_sel_hold; $rose(PINS.cke) |=> $changed(CK) [*8]; endproperty
   a_sel_hold: assert property (p_sel_hold)
      else $error("clock not kept running after wake");
   property p_pd_flag; POWERED_DOWN == !PINS.cke; endproperty
   a_pd_flag: assert property (p_pd_flag)
      else $error("power-down flag disagrees with clock enable");
endmodule

bind lpt_pd_ctrl lpt_pd_chk i_chk (.CLK, .RST_N, .CK, .POWERED_DOWN, .PINS);

// [sim/lpt_mem_model.sv]
// Purpose : Memory stand-in that answers training with a strobe pulse.
// Assumes : Counts memory clocks from the first command slot.
// Notes   : Slow answers come only when the bench raises late.
module lpt_mem_model (
   // Memory pins
   input wire logic               CK,
   input wire lpt_pkg::lpt_pins_s PINS,
   output logic                   DQS,
   // Scenario control
   input wire logic               late
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] cnt = 6'h00;
   initial DQS = 1'b0;
   // Strobe idles low; one pulse a set number of clocks after a command
   always @(posedge CK) begin
      if (PINS.cs) cnt <= late ? 6'h14 : 6'h06;
      else if (cnt != 6'h00) cnt <= cnt - 6'h01;
      DQS <= (cnt == 6'h01);
   end
endmodule

// [sim/tb_top.sv]
// Purpose : Self-checking bench for the power-down sequencer.
// Assumes : Each request is given at the edge that READY allows.
// Notes   : Hold times are judged by counting clock toggles.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK, RST_N, REQ, HOT, ACK, ERR, POWERED_DOWN, TRAIN_FAIL, CK, DQS;
   logic READY;
   logic late;
   lpt_pkg::lpt_req_s  REQ_DATA;
   lpt_pkg::lpt_pins_s PINS;
   int fail_count = 0;
   int checks     = 0;
   int tog;
   int lat;
   lpt_pd_ctrl #(.PPR_PROGRAM_CYC(50)) i_dut (.CLK, .RST_N, .REQ, .REQ_DATA,
      .HOT, .READY, .ACK, .ERR, .POWERED_DOWN, .TRAIN_FAIL, .CK, .PINS, .DQS);
   lpt_mem_model i_mem (.CK, .PINS, .DQS, .late);
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic tick;
      @(posedge CLK);
      #1;
   endtask
   // One request; toggles seen while asleep are counted for hold checks
   task automatic issue(input lpt_pkg::lpt_op_e op, input logic exp_err);
      logic ck_q;
      int   i;
      REQ_DATA = '{op, 6'h2A, 6'h15, lpt_pkg::FSP_LONG};
      REQ = 1'b1;
      tick;
      REQ = 1'b0;
      check(READY, 1'b0);
      tog = 0;
      lat = 0;
      ck_q = CK;
      // Lat is the edge count from the taking edge to the first slot
      for (i = 0; i < 3000 && ACK !== 1'b1; i++) begin
         tick;
         if (PINS.cke === 1'b0 && CK !== ck_q) tog++;
         if (PINS.cs === 1'b1 && lat == 0) lat = i + 1;
         ck_q = CK;
      end
      if (i == 3000) begin
         fail_count++;
         end_sim;
      end else begin
         check(ERR, exp_err);
         check(READY, 1'b1);
      end
   endtask
   // Guarded command, then a plain one that must wait out the guard
   task automatic s_gap(input lpt_pkg::lpt_op_e op, input int gap);
      issue(op, 1'b0);
      issue(lpt_pkg::OP_CMD, 1'b0);
      check(32'(lat + 1 >= gap), 32'h1);
   endtask
   // Hot round trip through power-down, then a FIFO write; 18 ns row
   // delay, derated or not, fits in one clock
   task automatic s_wfifo;
      HOT = 1'b1;
      issue(lpt_pkg::OP_PD_ENTER, 1'b0);
      issue(lpt_pkg::OP_PD_EXIT, 1'b0);
      issue(lpt_pkg::OP_WFIFO, 1'b0);
      check(32'(lat + 1 >= int'(lpt_pkg::XP_CYC + lpt_pkg::MPCWR_CYC)),
            32'h1);
      HOT = 1'b0;
   endtask
   // Command, power-down with its hold, refused command, wake
   task automatic s_pd(input lpt_pkg::lpt_op_e op, input int hold);
      issue(op, 1'b0);
      issue(lpt_pkg::OP_PD_ENTER, 1'b0);
      check(32'(tog >= hold), 32'h1);
      check(POWERED_DOWN, 1'b1);
      issue(lpt_pkg::OP_CMD, 1'b1);
      issue(lpt_pkg::OP_PD_EXIT, 1'b0);
      check(POWERED_DOWN, 1'b0);
      issue(lpt_pkg::OP_PD_EXIT, 1'b1);
   endtask
   // Training answered in time or after the deadline
   task automatic s_train(input logic slow);
      late = slow;
      issue(lpt_pkg::OP_TRAIN, 1'b0);
      repeat (40) tick;
      check(TRAIN_FAIL, slow);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Free-running controller clock
   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end
   // Main sequence
   initial begin
      RST_N = 1'b0;
      REQ = 1'b0;
      HOT = 1'b0;
      late = 1'b0;
      REQ_DATA = '0;
      repeat (10) tick;
      RST_N = 1'b1;
      s_pd(lpt_pkg::OP_MRW, int'(lpt_pkg::MRW_HOLD_CYC));
      // Calibration hold is shorter than the plain hold floor
      s_pd(lpt_pkg::OP_ZQ_START, int'(lpt_pkg::CK_HOLD_CYC));
      s_pd(lpt_pkg::OP_CMD, int'(lpt_pkg::CK_HOLD_CYC));
      s_gap(lpt_pkg::OP_OSC_STOP, 16);
      // 250 ns is 7 clocks, then 4 memory clocks of valid clock
      s_gap(lpt_pkg::OP_FSP_SWITCH, 7 + 8);
      s_gap(lpt_pkg::OP_ODT_UPDATE, 2);
      // Program cut to 50 clocks here, exit 1, address setting 1250
      s_gap(lpt_pkg::OP_PPR, 1301);
      s_wfifo;
      s_train(1'b0);
      s_train(1'b1);
      end_sim;
   end
endmodule
